/* hw/cgp_regs.sv */
// AXI4-Lite register bank with channel 4 gain and channel 5 config
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
module cgp_regs #(
  parameter int DATA_W = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite write
  input wire logic [cgp_pkg::CGP_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [cgp_pkg::CGP_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Channel datapath
  input wire logic [DATA_W-1:0] ch4_data_i,
  input wire logic ch4_valid_i,
  output logic [DATA_W-1:0] ch4_data_o,
  output logic ch4_valid_o,
  input wire logic [3:0] global_dc_block_setting_i,
  output logic [3:0] ch5_dc_block_o,
  output logic [9:0] ch5_phase_delay_o,
  output logic [1:0] ch5_input_select_o
);
  // ==========================================================
  // Reset synchroniser
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Word index from byte address; -1 if not aligned
  function automatic logic [8:0] word_idx(
      input logic [cgp_pkg::CGP_ADDR_W-1:0] a);
    if (a[1:0] != 2'b00) begin
      word_idx = 9'h1ff;
    end else begin
      word_idx = {1'b0, a[9:2]};
    end
  endfunction

  // ==========================================================
  // Register state
  logic [15:0] gain_high_reg, gain_high_next;
  logic [7:0] gain_low_reg, gain_low_next;
  cgp_pkg::cgp_ch5_config_t cfg_reg, cfg_next;
  logic aw_got_reg, aw_got_next;
  logic w_got_reg, w_got_next;
  logic [cgp_pkg::CGP_ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [8:0] widx, ridx;
  logic awready_reg, wready_reg, arready_reg;

  always_comb begin
    gain_high_next = gain_high_reg;
    gain_low_next = gain_low_reg;
    cfg_next = cfg_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    widx = word_idx(awaddr_reg);
    ridx = word_idx(s_axi_araddr_i);
    // Capture address and data independently, only on a handshake
    if (s_axi_awvalid_i && awready_reg) begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_reg) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata_i;
      wstrb_next = s_axi_wstrb_i;
    end
    if (aw_got_reg && w_got_reg) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = cgp_pkg::CGP_RESP_OKAY;
      if (widx == {1'b0, cgp_pkg::CGP_IDX_GAIN_HIGH}) begin
        if (wstrb_reg[0]) gain_high_next[7:0] = wdata_reg[7:0];
        if (wstrb_reg[1]) gain_high_next[15:8] = wdata_reg[15:8];
      end else if (widx == {1'b0, cgp_pkg::CGP_IDX_GAIN_LOW}) begin
        if (wstrb_reg[1]) gain_low_next = wdata_reg[15:8];
      end else if (widx == {1'b0, cgp_pkg::CGP_IDX_CH5_CONFIG}) begin
        if (wstrb_reg[0]) begin
          cfg_next.ch5_dc_block_off =
            wdata_reg[cgp_pkg::CGP_DC_OFF_BIT];
          cfg_next.ch5_input_select =
            cgp_pkg::cgp_in_sel_t'(wdata_reg[1:0]);
          cfg_next.ch5_phase_delay[1:0] = wdata_reg[7:6];
        end
        if (wstrb_reg[1]) cfg_next.ch5_phase_delay[9:2] = wdata_reg[15:8];
      end else begin
        bresp_next = cgp_pkg::CGP_RESP_SLVERR;
      end
    end
    if (bvalid_reg && s_axi_bready_i) bvalid_next = 1'b0;
    // Read: accept when no answer pending
    if (rvalid_reg && s_axi_rready_i) rvalid_next = 1'b0;
    if (s_axi_arvalid_i && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = cgp_pkg::CGP_RESP_OKAY;
      rdata_next = 32'h0000_0000;
      if (ridx == {1'b0, cgp_pkg::CGP_IDX_GAIN_HIGH}) begin
        rdata_next[15:0] = gain_high_reg;
      end else if (ridx == {1'b0, cgp_pkg::CGP_IDX_GAIN_LOW}) begin
        rdata_next[15:8] = gain_low_reg;
      end else if (ridx == {1'b0, cgp_pkg::CGP_IDX_CH5_CONFIG}) begin
        rdata_next[15:6] = cfg_reg.ch5_phase_delay;
        rdata_next[2] = cfg_reg.ch5_dc_block_off;
        rdata_next[1:0] = cfg_reg.ch5_input_select;
      end else begin
        rresp_next = cgp_pkg::CGP_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      gain_high_reg <= cgp_pkg::CGP_RST_GAIN_HIGH;
      gain_low_reg <= cgp_pkg::CGP_RST_GAIN_LOW;
      cfg_reg <= {cgp_pkg::CGP_RST_PHASE, cgp_pkg::CGP_RST_DC_OFF,
                  cgp_pkg::CGP_RST_MUX};
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else begin
      gain_high_reg <= gain_high_next;
      gain_low_reg <= gain_low_next;
      cfg_reg <= cfg_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Ready outputs registered; capture happens only while they are high
  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
    end else begin
      awready_reg <= !aw_got_next && !bvalid_next &&
                     !(aw_got_reg && w_got_reg);
      wready_reg <= !w_got_next && !bvalid_next && !(aw_got_reg && w_got_reg);
      arready_reg <= !rvalid_next;
    end
  end

  // ==========================================================
  // Gain datapath: unsigned product scaled by 2^-23
  logic [23:0] gain_word;
  logic [DATA_W+23:0] product;
  logic [DATA_W+23:0] scaled;
  logic [DATA_W-1:0] gain_out_next;
  logic [3:0] dc_next;
  always_comb begin
    gain_word = {gain_high_reg, gain_low_reg};
    product = {{24{1'b0}}, ch4_data_i} * {{DATA_W{1'b0}}, gain_word};
    scaled = product >> cgp_pkg::CGP_GAIN_FRAC;
    if (|scaled[DATA_W+23:DATA_W]) begin
      gain_out_next = '1;
    end else begin
      gain_out_next = scaled[DATA_W-1:0];
    end
    if (cfg_reg.ch5_dc_block_off) begin
      dc_next = 4'h0;
    end else begin
      dc_next = global_dc_block_setting_i;
    end
  end

  logic [DATA_W-1:0] ch4_data_reg;
  logic ch4_valid_reg;
  logic [3:0] dc_reg;
  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ch4_data_reg <= '0;
      ch4_valid_reg <= 1'b0;
      dc_reg <= 4'h0;
    end else begin
      ch4_data_reg <= gain_out_next;
      ch4_valid_reg <= ch4_valid_i;
      dc_reg <= dc_next;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign ch4_data_o = ch4_data_reg;
  assign ch4_valid_o = ch4_valid_reg;
  assign ch5_dc_block_o = dc_reg;
  assign ch5_phase_delay_o = cfg_reg.ch5_phase_delay;
  assign ch5_input_select_o = cfg_reg.ch5_input_select;
endmodule

/* pkg/cgp_pkg.sv */
// Package of constants and types for the channel gain/phase register bank
// Behaviour
// - Gain high register 0x20, resets 0x8000
// - Gain low byte 0x21; lower byte reads zero
// - Gain word unsigned, 0 to under 2.0
// - Phase delay bits 15:6, signed; 5:3 zero
// - DC-block off bit disables channel 5 filter
// - Bit clear: global DC-block setting applies
// - Bits 1:0 select channel 5 input
package cgp_pkg;
  // ==========================================================
  // Register indices and address width
  localparam logic [7:0] CGP_IDX_GAIN_HIGH = 8'h20;
  localparam logic [7:0] CGP_IDX_GAIN_LOW = 8'h21;
  localparam logic [7:0] CGP_IDX_CH5_CONFIG = 8'h22;
  localparam int CGP_ADDR_W = 10;
  // ==========================================================
  // Reset values
  localparam logic [15:0] CGP_RST_GAIN_HIGH = 16'h8000;
  localparam logic [7:0] CGP_RST_GAIN_LOW = 8'h00;
  localparam logic [9:0] CGP_RST_PHASE = 10'h000;
  localparam logic CGP_RST_DC_OFF = 1'b0;
  localparam logic [1:0] CGP_RST_MUX = 2'h0;
  // ==========================================================
  // Field positions, gain scale and response codes
  localparam int CGP_PHASE_LSB = 6;
  localparam int CGP_DC_OFF_BIT = 2;
  localparam int CGP_GAIN_FRAC = 23;
  localparam logic [1:0] CGP_RESP_OKAY = 2'h0;
  localparam logic [1:0] CGP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CGP_IN_NORMAL = 2'b00,
    CGP_IN_SHORT = 2'b01,
    CGP_IN_POS_TEST = 2'b10,
    CGP_IN_NEG_TEST = 2'b11
  } cgp_in_sel_t;

  typedef struct packed {
    logic [9:0] ch5_phase_delay;
    logic ch5_dc_block_off;
    cgp_in_sel_t ch5_input_select;
  } cgp_ch5_config_t;
endpackage

/* tb/cgp_regs_asserts.sv */
// Checker of the gain and channel 5 register bank
`timescale 1ns/10ps
module cgp_regs_asserts (
  input wire logic clk_i, rst_n_i,
  input wire logic [9:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i, s_axi_arready_o,
  input wire logic s_axi_rvalid_o, s_axi_rready_i,
  input wire logic s_axi_bvalid_o, s_axi_bready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o, ch5_input_select_o,
  input wire logic ch4_valid_i, ch4_valid_o,
  input wire logic [3:0] global_dc_block_setting_i, ch5_dc_block_o,
  input wire logic [9:0] ch5_phase_delay_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd(logic [9:0] a);
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == a;
  endsequence
  property p_bh; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o;
  endproperty
  a_bh: assert property (p_bh) else $error("bvalid");
  property p_rh; s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rdata_o);
  endproperty
  a_rh: assert property (p_rh) else $error("rdata");
  property p_lo; s_rd(10'h084) |=> s_axi_rdata_o[7:0] == 8'h00; endproperty
  a_lo: assert property (p_lo) else $error("low byte");
  property p_rs; s_rd(10'h088) |=> s_axi_rdata_o[5:3] == 3'h0; endproperty
  a_rs: assert property (p_rs) else $error("reserved");
  property p_bad; s_rd(10'h3fc) |=> s_axi_rresp_o == 2'h2; endproperty
  a_bad: assert property (p_bad) else $error("unmapped");
  property p_dc; ch5_dc_block_o != 4'h0 |->
    ch5_dc_block_o == $past(global_dc_block_setting_i); endproperty
  a_dc: assert property (p_dc) else $error("dc block");
  property p_vl; ch4_valid_i |=> ch4_valid_o; endproperty
  a_vl: assert property (p_vl) else $error("valid");
  property p_cf; $changed({ch5_phase_delay_o, ch5_input_select_o}) |->
    ##[0:2] $rose(s_axi_bvalid_o); endproperty
  a_cf: assert property (p_cf) else $error("config");
endmodule

/* tb/testbench.sv */
// Self-checking bench of the gain and channel 5 register bank
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'h0, rst_n_i = 1'h0;
  logic [9:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0, ch5_phase_delay_o;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, ch4_valid_i = 1'h0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, rd;
  logic [3:0] s_axi_wstrb_i = 4'h3, global_dc_block_setting_i = '0;
  logic [23:0] ch4_data_i = '0, ch4_data_o, g;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, ch4_valid_o, aw, w;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, ch5_input_select_o, rr;
  logic [3:0] ch5_dc_block_o;
  logic [15:0] c;
  int failures = 0, cmp_count = 0;
  cgp_regs DUT (.*);
  always #10 clk_i = ~clk_i;
  task chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {16'h0, d};
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    aw = 1'h1;
    w = 1'h1;
    while (aw || w) begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
      aw = aw && !s_axi_awready_o;
      w = w && !s_axi_wready_o;
    end
    do @(posedge clk_i); while (!s_axi_bvalid_o);
    rr = s_axi_bresp_o;
    s_axi_bready_i <= 1'h0;
  endtask
  task rdt(input logic [9:0] a);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do @(posedge clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'h0;
    do @(posedge clk_i); while (!s_axi_rvalid_o);
    rd = s_axi_rdata_o;
    rr = s_axi_rresp_o;
    s_axi_rready_i <= 1'h0;
  endtask
  function logic [23:0] gx(input logic [23:0] d, gw);
    logic [47:0] p;
    p = (48'(d) * 48'(gw)) >> 23;
    return (p > 48'hffffff) ? 24'hffffff : p[23:0];
  endfunction
  task dp(input logic [23:0] d);
    @(posedge clk_i);
    ch4_data_i <= d;
    ch4_valid_i <= 1'h1;
    @(posedge clk_i);
    ch4_valid_i <= 1'h0;
    #1;
    chk({31'h0, ch4_valid_o}, 32'h1);
    chk({8'h0, ch4_data_o}, {8'h0, gx(d, g)});
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    test_done();
  end
  initial begin
    void'($urandom(40));
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rdt(10'h080);
    chk(rd, 32'h8000);
    rdt(10'h084);
    chk(rd, 32'h0);
    rdt(10'h088);
    chk(rd, 32'h0);
    g = 24'h800000;
    dp(24'hffffff);
    for (int i = 0; i < 16; i++) begin
      g = (i == 0) ? 24'hffffff : (i == 1) ? 24'h0 : 24'($urandom);
      wr(10'h080, g[23:8]);
      chk({30'h0, rr}, 32'h0);
      wr(10'h084, {g[7:0], 8'h5a});
      rdt(10'h084);
      chk(rd, {16'h0, g[7:0], 8'h00});
      rdt(10'h080);
      chk(rd, {16'h0, g[23:8]});
      dp(24'($urandom));
      c = 16'($urandom);
      c[2:0] = 3'(i);
      @(posedge clk_i);
      global_dc_block_setting_i <= 4'($urandom);
      wr(10'h088, c);
      rdt(10'h088);
      chk(rd, {16'h0, c & 16'hffc7});
      repeat (2) @(posedge clk_i);
      #1;
      chk({22'h0, ch5_phase_delay_o}, {22'h0, c[15:6]});
      chk({30'h0, ch5_input_select_o}, {30'h0, c[1:0]});
      chk({28'h0, ch5_dc_block_o},
          c[2] ? 32'h0 : {28'h0, global_dc_block_setting_i});
    end
    wr(10'h3fc, 16'hffff);
    chk({30'h0, rr}, 32'h2);
    rdt(10'h3fc);
    chk({30'h0, rr}, 32'h2);
    chk(rd, 32'h0);
    test_done();
  end
endmodule
bind cgp_regs cgp_regs_asserts u_chk (.*);
